/* File: shared/cmi_pkg.sv */
// cmi_pkg: constants and types for the cyclic measurement input image framer
package cmi_pkg;

    // ------------------------------------------------------------------
    // image layout (field indices, each field one entry of the frame)
    // ------------------------------------------------------------------
    localparam int unsigned CMI_FIELD_CNT = 11;
    localparam logic [3:0] FLD_GROSS    = 4'h0;
    localparam logic [3:0] FLD_NET      = 4'h1;
    localparam logic [3:0] FLD_MAX      = 4'h2;
    localparam logic [3:0] FLD_MIN      = 4'h3;
    localparam logic [3:0] FLD_SPAN     = 4'h4;
    localparam logic [3:0] FLD_STAT1    = 4'h5;
    localparam logic [3:0] FLD_STAT2    = 4'h6;
    localparam logic [3:0] FLD_ACK1     = 4'h7;
    localparam logic [3:0] FLD_ACK2     = 4'h8;
    localparam logic [3:0] FLD_CONT     = 4'h9;
    localparam logic [3:0] FLD_CSTAT    = 4'hA;
    localparam logic [3:0] FLD_LAST     = 4'hA;

    // byte lengths of fields
    localparam logic [2:0] LEN_WORD = 3'h4;
    localparam logic [2:0] LEN_BYTE = 3'h1;

    // ------------------------------------------------------------------
    // primary status byte bits
    // ------------------------------------------------------------------
    localparam int unsigned S1_INVALID  = 0;
    localparam int unsigned S1_OVERLOAD = 1;
    localparam int unsigned S1_RANGE    = 2;
    localparam int unsigned S1_RSVD     = 3;
    localparam int unsigned S1_LIM_LO   = 4;

    // ------------------------------------------------------------------
    // detailed status word bits
    // ------------------------------------------------------------------
    localparam int unsigned S2_INVALID  = 0;
    localparam int unsigned S2_POS_OVL  = 1;
    localparam int unsigned S2_NEG_OVL  = 2;
    localparam int unsigned S2_POS_OVR  = 3;
    localparam int unsigned S2_NEG_OVR  = 4;
    localparam int unsigned S2_SCALE    = 5;
    localparam int unsigned S2_CAL      = 6;
    localparam int unsigned S2_LIMINIT  = 7;
    localparam int unsigned S2_LIM_LO   = 8;
    localparam int unsigned S2_EEPROM   = 12;
    localparam int unsigned S2_FLASH    = 13;
    localparam int unsigned S2_AUTOCAL  = 14;
    localparam int unsigned S2_TEDS     = 15;
    localparam int unsigned S2_TERM_LO  = 16;
    localparam int unsigned S2_TERM_CNT = 6;
    localparam int unsigned LIM_CNT     = 4;

    localparam logic [7:0]  STAT1_RST = 8'h00;
    localparam logic [31:0] STAT2_RST = 32'h0000_0000;

    // fixed point scaling
    localparam int unsigned DEC_MAX = 6;

    // ------------------------------------------------------------------
    // framer state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CMI_IDLE = 3'b001,
        CMI_SEND = 3'b010,
        CMI_DONE = 3'b100
    } cmi_state_t;

endpackage : cmi_pkg

/* File: shared/cmi_stream_if.sv */
// cmi_stream_if: byte stream with valid/ready between framer and buffer
`timescale 1ns/1ps
`default_nettype none
interface cmi_stream_if;
    logic [7:0] data;
    logic       last;
    logic       valid;
    logic       ready;
    modport src (output data, output last, output valid, input ready);
    modport snk (input data, input last, input valid, output ready);
endinterface : cmi_stream_if
`default_nettype wire

/* File: src/cmi_skid_buf.sv */
// cmi_skid_buf: two-entry buffer on the image byte stream
`timescale 1ns/1ps
`default_nettype none
module cmi_skid_buf
    import cmi_pkg::*;
(
    // clock and reset
    input  wire logic  core_clk,
    input  wire logic  reset_n,
    // filling side
    cmi_stream_if.snk  in_s,
    // draining side
    output var  logic [7:0] out_data,
    output var  logic       out_last,
    output var  logic       out_valid,
    input  wire logic       out_ready
);

    typedef struct packed {
        logic [1:0][8:0] mem;
        logic            wp;
        logic            rp;
        logic [1:0]      cnt;
    } cmi_buf_t;

    cmi_buf_t st_r, st_nxt;
    logic     push, pop;

    // ------------------------------------------------------------------
    // handshake
    // ------------------------------------------------------------------
    assign in_s.ready = (st_r.cnt != 2'h2);
    assign push       = in_s.valid && in_s.ready;
    assign pop        = out_valid && out_ready;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = {in_s.last, in_s.data};
            st_nxt.wp           = ~st_r.wp;
        end
        if (pop) begin
            st_nxt.rp = ~st_r.rp;
        end
        st_nxt.cnt = 2'(st_r.cnt + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // entries come straight from storage flops
    assign out_valid = (st_r.cnt != 2'h0);
    assign out_data  = st_r.mem[st_r.rp][7:0];
    assign out_last  = st_r.mem[st_r.rp][8];

endmodule : cmi_skid_buf
`default_nettype wire

/* File: src/cmi_image_framer.sv */
// cmi_image_framer: builds and streams the cyclic measurement input image
//
// Functional notes
// R01 - each measured value goes out as four bytes, float or fixed point
// R02 - fixed point form is two's complement over four bytes
// R03 - float and fixed point fields may be mixed per field
// R04 - fixed point values scaled by configured decimal places; code caps scaling at DEC_MAX (6), so decimals 7 scales by 10**6
// R05 - most significant byte of every field goes first
// R06 - master ignores undocumented status bits as reserved
// R07 - gross and net value fields; net is gross minus tare
// R08 - max and min peak fields plus peak-to-peak as max minus min
// R09 - two acknowledgment bytes echo the received control bytes
// R10 - read container word carries last requested parameter value
// R11 - container status byte holds error code and toggle bit
// R12 - status byte bits 0..2 invalid, overload, range; bit 3 zero
// R13 - status byte bits 4..7 flag limit switches one to four
// R14 - all status indications are active high
// R15 - second status is a 32 bit detailed error word
// R16 - word bits 0..4 invalid, pos/neg overload, pos/neg overrange
// R17 - word bits 5..7 scaling, calibration, limit switch init errors
// R18 - word bits 8..11 flag limit switches one to four
// R19 - word bits 12..14 eeprom, flash, autocalibration faults
// R20 - word bit 15 sensor id unreadable, checked only if always-teds set
// R21 - word bits 16..21 terminal faults, bits 22..31 read zero
`timescale 1ns/1ps
`default_nettype none
module cmi_image_framer
    import cmi_pkg::*;
(
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   reset_n,
    // measured values, signed fixed point in raw units
    input  wire logic signed [31:0]     gross_raw,
    input  wire logic signed [31:0]     tare_raw,
    input  wire logic signed [31:0]     max_raw,
    input  wire logic signed [31:0]     min_raw,
    // format selection and scaling
    input  wire logic [4:0]             float_sel,
    input  wire logic [2:0]             decimals,
    // control acknowledgment and container
    input  wire logic [7:0]             ctrl1_rx,
    input  wire logic [7:0]             ctrl2_rx,
    input  wire logic [31:0]            cont_value,
    input  wire logic [6:0]             cont_err,
    input  wire logic                   cont_toggle,
    // error conditions
    input  wire logic                   meas_invalid,
    input  wire logic                   pos_overload,
    input  wire logic                   neg_overload,
    input  wire logic                   pos_overrange,
    input  wire logic                   neg_overrange,
    input  wire logic                   scale_err,
    input  wire logic                   cal_err,
    input  wire logic                   lim_init_err,
    input  wire logic [3:0]             lim_trig,
    input  wire logic                   eeprom_err,
    input  wire logic                   flash_err,
    input  wire logic                   autocal_err,
    input  wire logic                   teds_unread,
    input  wire logic                   always_teds,
    input  wire logic [5:0]             term_fault,
    // cycle request
    input  wire logic                   image_req,
    output var  logic                   image_busy,
    // status outputs
    output var  logic [7:0]             primary_system_status,
    output var  logic [31:0]            detailed_system_status,
    // byte stream to the bus
    output var  logic [7:0]             tx_data,
    output var  logic                   tx_last,
    output var  logic                   tx_valid,
    input  wire logic                   tx_ready
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // fixed point scaling by powers of ten
    function automatic logic signed [31:0] scale_fix(input logic signed [31:0] v,
                                                     input logic [2:0] d);
        logic signed [31:0] r;
        r = v;
        for (int i = 0; i < DEC_MAX; i++) begin
            if (3'(i) < d) begin
                r = 32'(r * 32'sd10);
            end
        end
        return r;
    endfunction : scale_fix

    // integer to single precision float, truncating
    function automatic logic [31:0] to_float(input logic signed [31:0] v);
        logic [31:0] mag;
        logic [7:0]  ex;
        logic [31:0] norm;
        int          msb;
        mag  = v[31] ? 32'(-v) : 32'(v);
        msb  = 0;
        ex   = 8'h00;
        norm = 32'h0000_0000;
        for (int i = 0; i < 32; i++) begin
            if (mag[i]) begin
                msb = i;
            end
        end
        if (mag == 32'h0000_0000) begin
            return 32'h0000_0000;
        end
        norm = mag << (31 - msb);
        ex   = 8'(127 + msb);
        return {v[31], ex, norm[30:8]};
    endfunction : to_float

    // fixed point or float per field
    function automatic logic [31:0] fmt(input logic signed [31:0] v,
                                        input logic sel,
                                        input logic [2:0] d);
        return sel ? to_float(v) : scale_fix(v, d);  // [R01] [R02] [R03] [R04]
    endfunction : fmt

    // byte count of a field; primary status, ack and container status are single bytes
    function automatic logic [2:0] fld_len(input logic [3:0] f);
        unique case (f)
            FLD_STAT1, FLD_ACK1, FLD_ACK2, FLD_CSTAT: return LEN_BYTE;
            default:                                  return LEN_WORD;
        endcase
    endfunction : fld_len

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        cmi_state_t                       state;
        logic [3:0]                       fld;
        logic [1:0]                       bidx;
        logic [CMI_FIELD_CNT-1:0][31:0]   img;
        logic [7:0]                       s1;
        logic [31:0]                      s2;
    } cmi_frm_t;

    cmi_frm_t    st_r, st_nxt;
    cmi_stream_if bs();
    logic [7:0]  s1_c;
    logic [31:0] s2_c;
    logic [31:0] cur;

    // ------------------------------------------------------------------
    // status composition
    // ------------------------------------------------------------------
    always_comb begin
        s1_c = STAT1_RST;
        s1_c[S1_INVALID]  = meas_invalid;                      // [R12] [R14]
        s1_c[S1_OVERLOAD] = pos_overload | neg_overload;       // [R12]
        s1_c[S1_RANGE]    = pos_overrange | neg_overrange;     // [R12]
        s1_c[S1_RSVD]     = 1'b0;                              // [R12]
        s1_c[S1_LIM_LO +: LIM_CNT] = lim_trig;                 // [R13]

        s2_c = STAT2_RST;                                      // [R15] [R21]
        s2_c[S2_INVALID] = meas_invalid;                       // [R16] [R14]
        s2_c[S2_POS_OVL] = pos_overload;                       // [R16]
        s2_c[S2_NEG_OVL] = neg_overload;                       // [R16]
        s2_c[S2_POS_OVR] = pos_overrange;                      // [R16]
        s2_c[S2_NEG_OVR] = neg_overrange;                      // [R16]
        s2_c[S2_SCALE]   = scale_err;                          // [R17]
        s2_c[S2_CAL]     = cal_err;                            // [R17]
        s2_c[S2_LIMINIT] = lim_init_err;                       // [R17]
        s2_c[S2_LIM_LO +: LIM_CNT] = lim_trig;                 // [R18]
        s2_c[S2_EEPROM]  = eeprom_err;                         // [R19]
        s2_c[S2_FLASH]   = flash_err;                          // [R19]
        s2_c[S2_AUTOCAL] = autocal_err;                        // [R19]
        s2_c[S2_TEDS]    = teds_unread & always_teds;          // [R20]
        s2_c[S2_TERM_LO +: S2_TERM_CNT] = term_fault;          // [R21]
    end

    // ------------------------------------------------------------------
    // field length and current word
    // ------------------------------------------------------------------
    assign cur = st_r.img[st_r.fld];

    // msb first: byte index counts down from the field's top byte
    assign bs.data  = cur[8*st_r.bidx +: 8];                   // [R05]
    assign bs.valid = (st_r.state == CMI_SEND);
    assign bs.last  = (st_r.fld == FLD_LAST) && (st_r.bidx == 2'h0);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = s1_c;
        st_nxt.s2 = s2_c;
        unique case (st_r.state)
            CMI_IDLE: begin
                if (image_req) begin
                    // snapshot so the image stays consistent while it drains
                    st_nxt.img[FLD_GROSS] = fmt(gross_raw, float_sel[0], decimals); // [R07]
                    st_nxt.img[FLD_NET]   = fmt(32'(gross_raw - tare_raw),
                                                float_sel[1], decimals);           // [R07]
                    st_nxt.img[FLD_MAX]   = fmt(max_raw, float_sel[2], decimals);   // [R08]
                    st_nxt.img[FLD_MIN]   = fmt(min_raw, float_sel[3], decimals);   // [R08]
                    st_nxt.img[FLD_SPAN]  = fmt(32'(max_raw - min_raw),
                                                float_sel[4], decimals);           // [R08]
                    st_nxt.img[FLD_STAT1] = {24'h00_0000, s1_c};
                    st_nxt.img[FLD_STAT2] = s2_c;
                    st_nxt.img[FLD_ACK1]  = {24'h00_0000, ctrl1_rx};                // [R09]
                    st_nxt.img[FLD_ACK2]  = {24'h00_0000, ctrl2_rx};                // [R09]
                    st_nxt.img[FLD_CONT]  = cont_value;                             // [R10]
                    st_nxt.img[FLD_CSTAT] = {24'h00_0000, cont_toggle, cont_err};   // [R11]
                    st_nxt.fld   = FLD_GROSS;
                    st_nxt.bidx  = 2'(LEN_WORD - 3'h1);
                    st_nxt.state = CMI_SEND;
                end
            end
            CMI_SEND: begin
                if (bs.ready) begin
                    if (st_r.bidx != 2'h0) begin
                        st_nxt.bidx = 2'(st_r.bidx - 2'h1);                        // [R05]
                    end else if (st_r.fld == FLD_LAST) begin
                        st_nxt.state = CMI_DONE;
                    end else begin
                        st_nxt.fld  = 4'(st_r.fld + 4'h1);
                        st_nxt.bidx = 2'(fld_len(4'(st_r.fld + 4'h1)) - 3'h1);
                    end
                end
            end
            CMI_DONE: begin
                st_nxt.state = CMI_IDLE;
            end
            default: begin
                st_nxt.state = CMI_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r       <= '0;
            st_r.state <= CMI_IDLE;
            st_r.s1    <= STAT1_RST;
            st_r.s2    <= STAT2_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign image_busy             = (st_r.state != CMI_IDLE);
    assign primary_system_status  = st_r.s1;
    assign detailed_system_status = st_r.s2;

    // two-entry buffer so a stalled bus loses no byte
    cmi_skid_buf u_buf (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .in_s      (bs.snk),
        .out_data  (tx_data),
        .out_last  (tx_last),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

endmodule : cmi_image_framer
`default_nettype wire

/* File: tb/cmi_image_framer_assertions.sv */
// checker: port-level properties of the image framer
`timescale 1ns/1ps
`default_nettype none
module cmi_image_framer_checker (
    // clock and reset
    input wire logic        core_clk, reset_n,
    // error conditions
    input wire logic        meas_invalid, pos_overload, neg_overload,
    input wire logic        pos_overrange, neg_overrange, scale_err, cal_err,
    input wire logic        lim_init_err, eeprom_err, flash_err, autocal_err,
    input wire logic        teds_unread, always_teds,
    input wire logic [3:0]  lim_trig,
    input wire logic [5:0]  term_fault,
    // handshake and outputs
    input wire logic        image_req, image_busy, tx_last, tx_valid, tx_ready,
    input wire logic [7:0]  tx_data, primary_system_status,
    input wire logic [31:0] detailed_system_status
);
    // byte position within an image, wraps every 32 accepted bytes
    logic [4:0] beat_r;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) beat_r <= 5'h0;
        else if (tx_valid && tx_ready) beat_r <= beat_r + 5'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    property p_s1_err;
        $past(reset_n) |-> primary_system_status[2:0] == {$past(pos_overrange | neg_overrange),
            $past(pos_overload | neg_overload), $past(meas_invalid)};
    endproperty
    a_s1_err: assert property (p_s1_err) else $error("status byte error bits wrong");
    property p_s1_rsvd;
        primary_system_status[3] == 1'b0;
    endproperty
    a_s1_rsvd: assert property (p_s1_rsvd) else $error("status byte bit 3 set");
    property p_lim;
        $past(reset_n) |-> primary_system_status[7:4] == $past(lim_trig)
            && detailed_system_status[11:8] == $past(lim_trig);
    endproperty
    a_lim: assert property (p_lim) else $error("limit switch bits wrong");
    property p_s2_low;
        $past(reset_n) |-> detailed_system_status[7:0] == $past({lim_init_err, cal_err,
            scale_err, neg_overrange, pos_overrange, neg_overload, pos_overload, meas_invalid});
    endproperty
    a_s2_low: assert property (p_s2_low) else $error("status word low byte wrong");
    property p_s2_hw;
        $past(reset_n) |-> detailed_system_status[15:12] ==
            $past({teds_unread & always_teds, autocal_err, flash_err, eeprom_err});
    endproperty
    a_s2_hw: assert property (p_s2_hw) else $error("status word bits 12..15 wrong");
    property p_s2_term;
        $past(reset_n) |-> detailed_system_status[31:16] == {10'h000, $past(term_fault)};
    endproperty
    a_s2_term: assert property (p_s2_term) else $error("status word top bits wrong");
    property p_accept;
        image_req && !image_busy |=> image_busy;
    endproperty
    a_accept: assert property (p_accept) else $error("request not taken");
    property p_first;
        image_req && !image_busy && !tx_valid |-> ##2 tx_valid;
    endproperty
    a_first: assert property (p_first) else $error("first byte late");
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
    endproperty
    a_hold: assert property (p_hold) else $error("byte dropped during stall");
    property p_last;
        tx_valid && tx_ready |-> tx_last == (beat_r == 5'h1f);
    endproperty
    a_last: assert property (p_last) else $error("end marker misplaced");
    c_stall: cover property (tx_valid && !tx_ready);
    c_end: cover property (tx_valid && tx_ready && tx_last);
    c_refuse: cover property (image_req && image_busy);
endmodule : cmi_image_framer_checker
`default_nettype wire

/* File: tb/cmi_bus_master_model.sv */
// bus master model: takes image bytes, promptly or with stalls
`timescale 1ns/1ps
`default_nettype none
module cmi_bus_master_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // image byte stream
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    input  wire logic       tx_valid,
    output var  logic       tx_ready,
    // test control
    input  wire logic       slow,
    input  wire logic       clear
);
    logic [7:0] rx_mem [0:63];
    int         rx_cnt;
    int         last_idx;
    logic [1:0] phase_r;
    // bytes kept raw; the test compares reserved status bits along with the rest
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_cnt <= 0;
            last_idx <= -1;
            phase_r <= 2'h0;
            tx_ready <= 1'b0;
        end else begin
            if (tx_valid && tx_ready) begin
                rx_mem[rx_cnt[5:0]] <= tx_data;
                if (tx_last) last_idx <= rx_cnt;
            end
            if (clear) last_idx <= -1;
            rx_cnt <= clear ? 0 : rx_cnt + int'(tx_valid && tx_ready);
            phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
            // two stalls in three cycles when slow, so the buffer fills
            tx_ready <= #1 !slow || (phase_r == 2'h2);
        end
    end
endmodule : cmi_bus_master_model
`default_nettype wire

/* File: tb/cmi_image_framer_tb_top.sv */
// testbench top: image framer, bus master model and checker
`timescale 1ns/1ps
`default_nettype none
bind cmi_image_framer cmi_image_framer_checker u_chk (.core_clk(core_clk), .reset_n(reset_n),
    .meas_invalid(meas_invalid), .pos_overload(pos_overload), .neg_overload(neg_overload),
    .pos_overrange(pos_overrange), .neg_overrange(neg_overrange), .scale_err(scale_err),
    .cal_err(cal_err), .lim_init_err(lim_init_err), .eeprom_err(eeprom_err),
    .flash_err(flash_err), .autocal_err(autocal_err), .teds_unread(teds_unread),
    .always_teds(always_teds), .lim_trig(lim_trig), .term_fault(term_fault),
    .image_req(image_req), .image_busy(image_busy), .tx_last(tx_last), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .primary_system_status(primary_system_status),
    .detailed_system_status(detailed_system_status));
module cmi_image_framer_tb_top import cmi_pkg::*;;
    logic               core_clk = 1'b0;
    logic               reset_n = 1'b0;
    logic signed [31:0] gross_raw, tare_raw, max_raw, min_raw;
    logic [31:0]        cont_value, detailed_system_status;
    logic [7:0]         ctrl1_rx, ctrl2_rx, tx_data, primary_system_status;
    logic [6:0]         cont_err;
    logic [21:0]        errs;
    logic [4:0]         float_sel;
    logic [2:0]         decimals;
    logic               cont_toggle, always_teds, image_req, image_busy;
    logic               tx_last, tx_valid, tx_ready, slow, clear;
    int                 err_total = 0;
    int                 comparisons = 0;
    always #10 core_clk = ~core_clk;
    cmi_image_framer uut (.core_clk(core_clk), .reset_n(reset_n), .gross_raw(gross_raw),
        .tare_raw(tare_raw), .max_raw(max_raw), .min_raw(min_raw), .float_sel(float_sel),
        .decimals(decimals), .ctrl1_rx(ctrl1_rx), .ctrl2_rx(ctrl2_rx),
        .cont_value(cont_value), .cont_err(cont_err), .cont_toggle(cont_toggle),
        .meas_invalid(errs[0]), .pos_overload(errs[1]), .neg_overload(errs[2]),
        .pos_overrange(errs[3]), .neg_overrange(errs[4]), .scale_err(errs[5]),
        .cal_err(errs[6]), .lim_init_err(errs[7]), .lim_trig(errs[11:8]),
        .eeprom_err(errs[12]), .flash_err(errs[13]), .autocal_err(errs[14]),
        .teds_unread(errs[15]), .always_teds(always_teds), .term_fault(errs[21:16]),
        .image_req(image_req), .image_busy(image_busy),
        .primary_system_status(primary_system_status),
        .detailed_system_status(detailed_system_status), .tx_data(tx_data),
        .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready));
    cmi_bus_master_model master (.core_clk(core_clk), .reset_n(reset_n), .tx_data(tx_data),
        .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow),
        .clear(clear));
    task check(input logic [31:0] seen, input logic [31:0] expd);
        comparisons++;
        if (seen !== expd) begin
            err_total++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, expd);
        end
    endtask : check
    task print_verdict;
        $display("mismatches %0d, comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // exact only below 2**24, so stimulus stays small
    function logic [31:0] to_float(input logic signed [31:0] v);
        logic [31:0] a;
        int          p;
        if (v == 0) return 32'h0000_0000;
        a = (v < 0) ? -v : v;
        p = 31;
        while (!a[p]) p--;
        return {v[31], 8'(127 + p), 23'(a << (23 - p))};
    endfunction : to_float
    function logic [31:0] conv(input logic signed [31:0] v, input logic f, input logic [2:0] d);
        logic [31:0] r;
        r = v;
        if (f) return to_float(v);
        for (int i = 0; i < d; i++) r = r * 10;
        return r;
    endfunction : conv
    task run_image(input logic [2:0] dec, input logic [4:0] fs, input logic sl,
                   input logic [21:0] e, input logic at);
        logic [255:0] img;
        logic [7:0]   s1;
        logic [31:0]  s2;
        int           n;
        @(posedge core_clk) #1;
        decimals = dec;
        float_sel = fs;
        slow = sl;
        errs = e;
        always_teds = at;
        clear = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 clear = 1'b0;
        s1 = {e[11:8], 1'b0, e[3] | e[4], e[1] | e[2], e[0]};
        s2 = {10'h000, e[21:16], e[15] & at, e[14:0]};
        check(32'(primary_system_status), 32'(s1));
        check(detailed_system_status, s2);
        img = {conv(gross_raw, fs[0], dec), conv(gross_raw - tare_raw, fs[1], dec),
               conv(max_raw, fs[2], dec), conv(min_raw, fs[3], dec),
               conv(max_raw - min_raw, fs[4], dec), s1, s2, ctrl1_rx, ctrl2_rx,
               cont_value, cont_toggle, cont_err};
        image_req = 1'b1;
        @(posedge core_clk) #1 image_req = 1'b0;
        // inputs move after the request; the image must keep the snapshot
        errs = ~e;
        @(posedge core_clk) #1 image_req = 1'b1;
        @(posedge core_clk) #1 image_req = 1'b0;
        n = 0;
        while (master.rx_cnt < 32 && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        repeat (20) @(posedge core_clk);
        check(32'(master.rx_cnt), 32'h0000_0020);
        check(32'(master.last_idx), 32'h0000_001F);
        for (int i = 0; i < 32; i++) begin
            check(32'(master.rx_mem[i]), 32'(img[255 - 8 * i -: 8]));
        end
    endtask : run_image
    initial begin
        gross_raw = 32'h0000_04D2;
        tare_raw = 32'h0000_0064;
        max_raw = 32'h0000_1388;
        min_raw = 32'hFFFF_FC18;
        ctrl1_rx = 8'hA5;
        ctrl2_rx = 8'h3C;
        cont_value = 32'hDEAD_BEEF;
        cont_err = 7'h5A;
        cont_toggle = 1'b1;
        {errs, always_teds, float_sel, decimals} = '0;
        {image_req, slow, clear} = '0;
        repeat (6) @(posedge core_clk);
        #1 reset_n = 1'b1;
        run_image(3'h2, 5'h00, 1'b1, 22'h2A_5A5A, 1'b1);
        run_image(3'h0, 5'h15, 1'b0, 22'h15_A5A5, 1'b0);
        run_image(3'(DEC_MAX), 5'h0A, 1'b1, 22'h3F_FFFF, 1'b1);
        print_verdict;
    end
    initial begin
        #100_000;
        err_total++;
        print_verdict;
    end
endmodule : cmi_image_framer_tb_top
`default_nettype wire
